// ### core/eep_defines.svh
// eep_defines.svh: offsets, codes and timing counts of the serial eeprom slave
// assumes a 50 MHz system clock and an i2c bus of up to 400 kHz on the pins
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH
// fixed upper nibble of the 7-bit device address
`define EEP_DEV_TYPE 4'hA
// array size in bytes and page size in bytes
`define EEP_MEM_BYTES 256
`define EEP_PAGE_BYTES 8
// bit counter value of the ninth (acknowledge) clock
`define EEP_ACK_BIT 4'h8
// page commit walker value when idle
`define EEP_CM_DONE 4'h8
// reset level of the pin synchronisers (idle bus is high)
`define EEP_PIN_IDLE 1'b1
// system clock rate and self-timed programming bound
`define EEP_MCLK_HZ 50000000
`define EEP_PROG_TIME_MS 10
`define EEP_PROG_CYCLES ((`EEP_PROG_TIME_MS * `EEP_MCLK_HZ) / 1000)
`endif

// ### core/eep_pkg.sv
// eep_pkg: types shared by the serial eeprom slave
// assumes eep_defines.svh supplies the numeric constants
`default_nettype none
package eep_pkg;
  // protocol phases of the slave
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_MADDR,
    ST_WDATA,
    ST_RDATA,
    ST_SKIP
  } eep_state_t;
  // filtered pin levels, travelling together
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] sel;
  } eep_pins_t;
endpackage
`default_nettype wire

// ### core/eep_prog_timer.sv
// eep_prog_timer: self-timed programming interval counter
// assumes a one-cycle start pulse on the system clock
`include "eep_defines.svh"
`default_nettype none
module eep_prog_timer #(
  parameter int unsigned CYCLES = `EEP_PROG_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_start,
  output logic o_busy
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;

  // load on start, count down to zero
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else if (i_start) begin
      cnt_q <= W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign o_busy = (cnt_q != '0);

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  chk_cycle_bound: assert property (cnt_q <= W'(CYCLES))
    else $error("programming count above bound");
  chk_cycle_load: assert property (i_start |=> cnt_q == W'(CYCLES))
    else $error("programming count not loaded");
endmodule
`default_nettype wire

// ### core/eep_slave.sv
// eep_slave: command logic of a 2 Kbit two-wire serial eeprom, slave side
// assumes open-drain scl/sda resolved outside; scl is also the link clock
//
// What this block does
// - answer 7-bit address 1010 plus the three device select pins
// - hold 256 bytes, addressed by one 8-bit memory address word
// - write starts with address byte, direction 0; acknowledge on ninth clock
// - accept and acknowledge memory address, then acknowledge each data byte
// - stop after written data starts programming; bus ignored until done
// - further bytes instead of stop: page mode, up to 8 bytes
// - low three address bits step per byte and wrap inside the page
// - programming cycle lasts at most 10 ms
// - address during programming gets no acknowledge; acknowledge once finished
// - address counter holds last accessed location plus one; after a write only the low three bits step
// - direction 1: acknowledge, then shift out counter byte, msb first
// - master not-acknowledge then stop ends the read; back to standby
// - read past last location of last page wraps counter to zero
// - write at last page location wraps counter to page start
// - write protect low allows programming
// - random read: write address only, restart, then current read
// - master acknowledge advances address and sends next byte, wrapping
`include "eep_defines.svh"
`default_nettype none
module eep_slave #(
  parameter int unsigned PROG_CYCLES = `EEP_PROG_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_wp,
  input wire logic [2:0] i_device_select_pins,
  output logic o_prog_busy
);
  localparam int NPIN = 6;

  logic link_clr_q;
  logic tog_q;
  logic cap_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic seen_q;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_f;
  eep_pkg::eep_pins_t pin;
  logic scl_prev_q;
  logic sda_prev_q;
  eep_pkg::eep_state_t st_q;
  eep_pkg::eep_state_t st_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic drive_q;
  logic drive_d;
  logic pend_q;
  logic pend_d;
  logic clr_d;
  logic [3:0] cm_q;
  logic [7:0] pmask_q;
  logic [7:0] pbuf_q [`EEP_PAGE_BYTES];
  logic [7:0] mem_q [`EEP_MEM_BYTES];
  logic busy;

  // link side: sample sda on each scl rise and flag it by a toggle;
  // held clear between frames so no edge is counted outside one
  always_ff @(posedge i_scl or posedge link_clr_q) begin
    if (link_clr_q) begin
      tog_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      cap_q <= i_sda;
    end
  end

  // toggle crosses into the system clock; cap_q is stable by then
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      seen_q <= tog_s2_q;
    end
  end

  // pins pass three flops; a level counts once stages two and three agree
  assign pin_raw = {i_scl, i_sda, i_wp, i_device_select_pins};
  generate
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic f_q;
      always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
          s1_q <= `EEP_PIN_IDLE;
          s2_q <= `EEP_PIN_IDLE;
          s3_q <= `EEP_PIN_IDLE;
          f_q <= `EEP_PIN_IDLE;
        end else begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            f_q <= s3_q;
          end
        end
      end
      assign pin_f[g] = f_q;
    end
  endgenerate
  assign pin = pin_f;

  // previous filtered bus levels for edge and condition detection
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= pin.scl;
      sda_prev_q <= pin.sda;
    end
  end

  // bus events and byte decodes
  wire rise_ev = (tog_s2_q != seen_q) && !link_clr_q;
  wire fall_ev = scl_prev_q && !pin.scl;
  wire scl_hi = scl_prev_q && pin.scl;
  wire start_ev = scl_hi && sda_prev_q && !pin.sda;
  wire stop_ev = scl_hi && !sda_prev_q && pin.sda;
  wire at_ack = (bit_q == `EEP_ACK_BIT);
  wire byte_done = rise_ev && at_ack;
  wire ack_fall = fall_ev && at_ack;
  wire dev_hit = (sh_q[7:1] == {`EEP_DEV_TYPE, pin.sel});
  wire dev_ok = dev_hit && !busy;
  wire rd_dir = sh_q[0];
  wire [7:0] mem_rd = mem_q[addr_q];
  wire [7:0] addr_page = {addr_q[7:3], 3'(addr_q[2:0] + 3'h1)};
  wire [7:0] addr_next = 8'(addr_q + 8'h01);
  wire prog_start = stop_ev && pend_q && !pin.wp;

  // protocol sequencing; drive_q at the ninth rise tells if we acknowledged
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    out_d = out_q;
    addr_d = addr_q;
    drive_d = drive_q;
    pend_d = pend_q;
    clr_d = link_clr_q;
    if (rise_ev && !at_ack) begin
      bit_d = 4'(bit_q + 4'h1);
      sh_d = {sh_q[6:0], cap_q};
      out_d = {out_q[6:0], 1'b0};
    end
    if (byte_done) begin
      bit_d = 4'h0;
    end
    if (fall_ev) begin
      drive_d = 1'b0;
    end
    unique case (st_q)
      eep_pkg::ST_IDLE, eep_pkg::ST_SKIP: begin
      end
      eep_pkg::ST_DEV: begin
        if (ack_fall) begin
          drive_d = dev_ok;
        end
        if (byte_done && !drive_q) begin
          st_d = eep_pkg::ST_SKIP;
        end else if (byte_done && rd_dir) begin
          st_d = eep_pkg::ST_RDATA;
          out_d = mem_rd;
          addr_d = addr_next;
        end else if (byte_done) begin
          st_d = eep_pkg::ST_MADDR;
        end
      end
      eep_pkg::ST_MADDR: begin
        if (ack_fall) begin
          drive_d = 1'b1;
        end
        if (byte_done) begin
          addr_d = sh_q;
          st_d = eep_pkg::ST_WDATA;
        end
      end
      eep_pkg::ST_WDATA: begin
        if (ack_fall) begin
          drive_d = 1'b1;
        end
        if (byte_done) begin
          addr_d = addr_page;
          pend_d = 1'b1;
        end
      end
      eep_pkg::ST_RDATA: begin
        if (fall_ev && !at_ack) begin
          drive_d = !out_q[7];
        end
        if (byte_done && cap_q) begin
          st_d = eep_pkg::ST_SKIP;
        end else if (byte_done) begin
          out_d = mem_rd;
          addr_d = addr_next;
        end
      end
      default: begin
        st_d = eep_pkg::ST_IDLE;
      end
    endcase
    // a start, also a repeated one, opens a new address phase
    if (start_ev) begin
      st_d = eep_pkg::ST_DEV;
      bit_d = 4'h0;
      drive_d = 1'b0;
      clr_d = 1'b0;
    end
    // a stop ends any transfer and parks the link side
    if (stop_ev) begin
      st_d = eep_pkg::ST_IDLE;
      bit_d = 4'h0;
      drive_d = 1'b0;
      clr_d = 1'b1;
      pend_d = 1'b0;
    end
  end

  // sequencer registers
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      st_q <= eep_pkg::ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      out_q <= 8'h00;
      addr_q <= 8'h00;
      drive_q <= 1'b0;
      pend_q <= 1'b0;
      link_clr_q <= 1'b1;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      out_q <= out_d;
      addr_q <= addr_d;
      drive_q <= drive_d;
      pend_q <= pend_d;
      link_clr_q <= clr_d;
    end
  end

  // page buffer: each data byte lands at its page offset, later ones overwrite
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      pmask_q <= 8'h00;
    end else if (byte_done && st_q == eep_pkg::ST_MADDR) begin
      pmask_q <= 8'h00;
    end else if (byte_done && st_q == eep_pkg::ST_WDATA) begin
      pmask_q[addr_q[2:0]] <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (byte_done && st_q == eep_pkg::ST_WDATA) begin
      pbuf_q[addr_q[2:0]] <= sh_q;
    end
  end

  // commit walker copies the page into the array at programming start
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cm_q <= `EEP_CM_DONE;
    end else if (prog_start) begin
      cm_q <= 4'h0;
    end else if (cm_q != `EEP_CM_DONE) begin
      cm_q <= 4'(cm_q + 4'h1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (cm_q != `EEP_CM_DONE && pmask_q[cm_q[2:0]]) begin
      mem_q[{addr_q[7:3], cm_q[2:0]}] <= pbuf_q[cm_q[2:0]];
    end
  end

  // self-timed programming interval; bus gets no acknowledge meanwhile
  eep_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_start(prog_start),
    .o_busy(busy)
  );

  // open-drain data pin: only ever pulled low
  assign o_sda = 1'b0;
  assign o_sda_oe = drive_q;
  assign o_prog_busy = busy;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  chk_ack_match: assert property (
    ack_fall && st_q == eep_pkg::ST_DEV && dev_ok |=> o_sda_oe)
    else $error("matching address not acknowledged");
  chk_nack_busy: assert property (
    st_q == eep_pkg::ST_DEV && busy |-> !o_sda_oe)
    else $error("address acknowledged while programming");
  chk_byte_ack: assert property (
    ack_fall && (st_q == eep_pkg::ST_MADDR || st_q == eep_pkg::ST_WDATA)
    |=> o_sda_oe ##1 o_sda_oe)
    else $error("written byte not acknowledged");
  chk_page_wrap: assert property (
    byte_done && st_q == eep_pkg::ST_WDATA
    |=> addr_q == {$past(addr_q[7:3]), 3'($past(addr_q[2:0]) + 3'h1)})
    else $error("page offset did not step within page");
  chk_read_msb: assert property (
    fall_ev && st_q == eep_pkg::ST_RDATA && !at_ack
    |=> o_sda_oe == !$past(out_q[7]))
    else $error("read bit not driven msb first");
  chk_read_incr: assert property (
    byte_done && st_q == eep_pkg::ST_RDATA && !cap_q
    |=> addr_q == 8'($past(addr_q) + 8'h01) && out_q == $past(mem_rd))
    else $error("read address did not advance");
  chk_prog_start: assert property (
    stop_ev && pend_q && !pin.wp |=> o_prog_busy [*2])
    else $error("programming not started after stop");
  chk_wp_hold: assert property (
    stop_ev && pin.wp && !o_prog_busy |=> !o_prog_busy)
    else $error("programming started while protected");
  chk_stop_idle: assert property (
    stop_ev |=> st_q == eep_pkg::ST_IDLE && !o_sda_oe)
    else $error("stop did not return to standby");
endmodule
`default_nettype wire

// ### verif/eep_i2c_master.sv
// eep_i2c_master: behavioural two-wire bus master facing the eeprom slave
// assumes the bench resolves sda with a pull-up; scl idles high between frames
`default_nettype none
module eep_i2c_master (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter of an scl phase; phases of 1 us keep the slave's pin filter happy
  localparam int Q = 250;
  // bus released at time zero
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  // start or repeated start: sda falls while scl is high
  task automatic start();
    #(Q + 3);
    o_sda = 1'h1;
    #(Q);
    o_scl = 1'h1;
    #(2 * Q);
    o_sda = 1'h0;
    #(2 * Q);
    o_scl = 1'h0;
  endtask
  // stop: sda rises while scl is high, after a nack it ends a read
  task automatic stop();
    #(Q);
    o_sda = 1'h0;
    #(Q);
    o_scl = 1'h1;
    #(2 * Q);
    o_sda = 1'h1;
    #(4 * Q);
  endtask
  // one bus clock: data set while scl low, sampled in mid high phase
  task automatic bit_io(input logic b, output logic s);
    #(Q);
    o_sda = b;
    #(3 * Q);
    o_scl = 1'h1;
    #(2 * Q);
    s = i_sda;
    #(2 * Q);
    o_scl = 1'h0;
  endtask
  // send a byte msb first, then release sda for the ack clock
  task automatic put(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
    end
    bit_io(1'h1, ack);
  endtask
  // take a byte msb first and answer it; nack marks the last one
  task automatic get(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, s);
      v[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule
`default_nettype wire

// ### verif/eep_slave_tb.sv
// eep_slave_tb: self-checking bench of the serial eeprom slave
// assumes eep_i2c_master as bus partner; select pins at 011 except in one address probe
`default_nettype none
module eep_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 3000;
  localparam logic [6:0] DEV = 7'h53;
  logic i_mclk = 1'h0;
  logic i_rstn = 1'h0;
  logic i_wp = 1'h0;
  logic [2:0] sel = 3'h3;
  logic m_scl, m_sda, sda, o_sda, oe, busy, a;
  logic [7:0] d;
  logic [7:0] mem [8];
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int blen = 0;
  // system clock and open-drain data wire with pull-up
  always #10 i_mclk = ~i_mclk;
  assign sda = m_sda & (oe ? o_sda : 1'h1);
  eep_slave #(.PROG_CYCLES(PROG)) u_eep_slave (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_scl(m_scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(oe), .i_wp(i_wp),
    .i_device_select_pins(sel), .o_prog_busy(busy));
  eep_i2c_master u_eep_i2c_master (.o_scl(m_scl), .o_sda(m_sda), .i_sda(sda));
  // hang guard and programming length counter
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (busy === 1'h1) begin
      blen <= blen + 1;
    end
    if (cycles == 80000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // start a frame and send the address byte
  task automatic hail(input logic [6:0] dev, input logic rd, output logic ack);
    u_eep_i2c_master.start();
    u_eep_i2c_master.put({dev, rd}, ack);
  endtask
  // foreign address refused, then accepted once the select pins match it
  task automatic t_wrong();
    hail(7'h57, 1'h0, a);
    check(a, 1'h1);
    u_eep_i2c_master.stop();
    @(posedge i_mclk) sel <= 3'h7;
    hail(7'h57, 1'h0, a);
    check(a, 1'h0);
    u_eep_i2c_master.stop();
    @(posedge i_mclk) sel <= 3'h3;
  endtask
  // ten bytes from offset 6 wrap inside page 0
  task automatic t_page();
    hail(DEV, 1'h0, a);
    check(a, 1'h0);
    u_eep_i2c_master.put(8'h06, a);
    check(a, 1'h0);
    for (int i = 0; i < 10; i++) begin
      u_eep_i2c_master.put(8'hD0 + i[7:0], a);
      mem[(6 + i) % 8] = 8'hD0 + i[7:0];
      check(a, 1'h0);
    end
    u_eep_i2c_master.stop();
  endtask
  task automatic t_poll();
    check(busy, 1'h1);
    hail(DEV, 1'h0, a);
    check(a, 1'h1);
    u_eep_i2c_master.stop();
    for (int i = 0; i < 4000 && busy !== 1'h0; i++) begin
      @(negedge i_mclk);
    end
    check(blen[15:0], PROG[15:0]);
    hail(DEV, 1'h0, a);
    check(a, 1'h0);
    u_eep_i2c_master.stop();
  endtask
  // counter wrapped to page start after the write at offset 7
  task automatic t_seq();
    hail(DEV, 1'h1, a);
    check(a, 1'h0);
    for (int i = 0; i < 8; i++) begin
      u_eep_i2c_master.get(i == 7, d);
      check(d, mem[i]);
    end
    u_eep_i2c_master.stop();
    check(oe, 1'h0);
  endtask
  task automatic t_wp();
    @(posedge i_mclk) i_wp <= 1'h1;
    hail(DEV, 1'h0, a);
    u_eep_i2c_master.put(8'h03, a);
    u_eep_i2c_master.put(8'h55, a);
    check(a, 1'h0);
    u_eep_i2c_master.stop();
    check(busy, 1'h0);
    @(posedge i_mclk) i_wp <= 1'h0;
  endtask
  // top location written first, so the random read from it rolls over to zero
  task automatic t_wrap();
    hail(DEV, 1'h0, a);
    u_eep_i2c_master.put(8'hFF, a);
    u_eep_i2c_master.put(8'h5A, a);
    check(a, 1'h0);
    u_eep_i2c_master.stop();
    for (int i = 0; i < 4000 && busy !== 1'h0; i++) begin
      @(negedge i_mclk);
    end
    hail(DEV, 1'h0, a);
    u_eep_i2c_master.put(8'hFF, a);
    hail(DEV, 1'h1, a);
    check(a, 1'h0);
    u_eep_i2c_master.get(1'h0, d);
    check(d, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      u_eep_i2c_master.get(i == 3, d);
      check(d, mem[i]);
    end
    u_eep_i2c_master.stop();
    hail(DEV, 1'h1, a);
    u_eep_i2c_master.get(1'h1, d);
    check(d, mem[4]);
    u_eep_i2c_master.stop();
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rstn <= 1'h1;
    repeat (10) @(posedge i_mclk);
    check(oe, 1'h0);
    check(busy, 1'h0);
    t_wrong();
    t_page();
    t_poll();
    t_seq();
    t_wp();
    t_wrap();
    wrap_up();
  end
endmodule
`default_nettype wire
